// file: dv/asp_remote.sv
// Remote serial device model facing one port of the core.
// Assumes BIT clocks per bit, eight data bits, no parity, idle-high line.
`timescale 1ns/1ps
`default_nettype none
module asp_remote #(
	parameter int BIT = 16
)
(
	// Clock
	input wire logic clk,
	// Line
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] got;
	int got_n = 0;
	initial line_out = 1'b1;
	// The stop level is a choice so that a broken frame can be sent.
	task automatic send(input logic [7:0] b, input logic stop_lvl);
		logic [9:0] f;
		f = {stop_lvl, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_out <= f[i];
			repeat (BIT) @(posedge clk);
		end
		line_out <= 1'b1;
		repeat (BIT) @(posedge clk);
	endtask
	always
	begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clk);
			got[i] = line_in;
		end
		repeat (BIT) @(posedge clk);
		got_n++;
	end
endmodule
`default_nettype wire

// file: dv/test_async_serial_port_core.sv
// Self-checking bench for the two-port serial core.
// Port 0 faces the remote model; port 1 is looped back onto itself.
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_port_core;
	import asp_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0][7:0] lfc = {8'h70, 8'h70};
	logic [1:0][15:0] div_i = {16'h0001, 16'h0001};
	logic [1:0][5:0] div_f = '0;
	logic [1:0] enab = 2'b11;
	logic [1:0][INT_W-1:0] imask = '0;
	logic [1:0][INT_W-1:0] iclr = '0;
	logic cts0 = 1'b0;
	logic [1:0][7:0] tx_data = '0;
	logic [1:0] tx_valid = '0;
	logic [1:0] rx_ready = '0;
	logic [1:0] sout, rts_n, tx_ready, rx_valid, busy, irq, txd, rxd;
	logic [1:0][11:0] rx_data;
	logic [1:0][INT_W-1:0] iraw;
	logic line0;
	int num_errors = 0;
	int checked = 0;
	int k;
	bit ok;
	always #4 clk = ~clk;
	asp_top u_asp_top (.clk(clk), .resetn(resetn), .line_format_control(lfc),
		.divisor_integer_part(div_i), .divisor_fraction_part(div_f), .port_enable(enab),
		.tx_enable(enab), .rx_enable(enab), .cts_flow_en(2'b01), .rts_flow_en(2'b01),
		.int_mask(imask), .int_clear(iclr), .serial_in({sout[1], line0}),
		.clear_to_send_n({1'b0, cts0}), .serial_out(sout), .request_to_send_n(rts_n),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .busy(busy), .int_raw(iraw),
		.interrupt_out(irq), .tx_dma_req(txd), .rx_dma_req(rxd));
	asp_remote u_asp_remote (.clk(clk), .line_in(sout[0]), .line_out(line0));
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("Checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic stall();
		if (!ok)
		begin
			num_errors++;
			$display("Error wait timed out");
			results();
		end
	endtask
	task automatic push(input int g, input logic [7:0] b, input int lim);
		ok = 0;
		@(posedge clk);
		tx_data[g] <= b;
		tx_valid[g] <= 1'b1;
		for (int n = 0; n < lim && !ok; n++)
		begin
			#1;
			ok = (tx_ready[g] === 1'b1);
			@(posedge clk);
		end
		tx_valid[g] <= 1'b0;
	endtask
	task automatic pop(input int g, input logic [11:0] exp);
		ok = 0;
		for (int n = 0; n < 3000 && !ok; n++)
		begin
			@(posedge clk);
			#1;
			ok = (rx_valid[g] === 1'b1);
		end
		stall();
		chk("rx word", rx_data[g], exp);
		@(posedge clk);
		rx_ready[g] <= 1'b1;
		@(posedge clk);
		rx_ready[g] <= 1'b0;
	endtask
	task automatic wait_got(input int n);
		ok = 0;
		for (int i = 0; i < 8000 && !ok; i++)
		begin
			@(posedge clk);
			ok = (u_asp_remote.got_n >= n);
		end
		stall();
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("line idle", 12'(sout), 12'h003);
		chk("tx ready", 12'(tx_ready), 12'h003);
		chk("rts", 12'(rts_n), 12'h000);
		$display("Test reset done");
		@(posedge clk);
		for (k = 0; k < 4; k++)
		begin
			lfc[1] <= {1'b0, 2'(k), 1'b1, k[0], k[1], 1'b1, 1'b0};
			push(1, 8'hd6, 2000);
			stall();
			pop(1, 12'(8'hd6 & (8'hff >> (3 - k))));
		end
		$display("Test formats done");
		push(0, 8'h5a, 2000);
		stall();
		wait_got(1);
		chk("remote byte", 12'(u_asp_remote.got), 12'h05a);
		u_asp_remote.send(8'h3c, 1'b1);
		pop(0, 12'h03c);
		u_asp_remote.send(8'h81, 1'b0);
		pop(0, 12'h181);
		u_asp_remote.send(8'h00, 1'b0);
		pop(0, 12'h500);
		chk("error request", 12'(iraw[0][INT_ERR]), 12'h001);
		iclr[0] <= 5'h10;
		@(posedge clk);
		iclr[0] <= 5'h00;
		repeat (2) @(posedge clk);
		#1;
		chk("error cleared", 12'(iraw[0][INT_ERR]), 12'h000);
		$display("Test serial done");
		@(posedge clk);
		cts0 <= 1'b1;
		imask[0] <= 5'h04;
		repeat (8) @(posedge clk);
		k = 0;
		for (int i = 0; i < 33; i++)
		begin
			push(0, 8'(i), 40);
			k += ok;
		end
		chk("fifo depth", 12'(k), 12'h020);
		chk("tx irq low", 12'(irq), 12'h000);
		chk("cts hold", 12'(u_asp_remote.got_n), 12'h001);
		chk("busy", 12'(busy[0]), 12'h001);
		chk("tx dma full", 12'(txd[0]), 12'h000);
		cts0 <= 1'b0;
		wait_got(33);
		repeat (4) @(posedge clk);
		#1;
		chk("tx irq high", 12'(irq), 12'h001);
		chk("tx dma ready", 12'(txd[0]), 12'h001);
		@(posedge clk);
		imask[0] <= 5'h00;
		repeat (2) @(posedge clk);
		#1;
		chk("tx irq masked", 12'(irq), 12'h000);
		$display("Test fifo done");
		// The remote honours request-to-send: it stops once the receiver asks.
		@(posedge clk);
		for (k = 0; k < 40 && rts_n[0] === 1'b0; k++)
		begin
			u_asp_remote.send(8'(k), 1'b1);
		end
		chk("rts raised", 12'(k), 12'h01e);
		repeat (520) @(posedge clk);
		chk("rx timeout", 12'(iraw[0][INT_RXTO]), 12'h001);
		chk("rx dma", 12'(rxd[0]), 12'h001);
		for (int i = 0; i < 30; i++)
		begin
			pop(0, 12'(i));
		end
		chk("rts lowered", 12'(rts_n[0]), 12'h000);
		$display("Test flow done");
		@(posedge clk);
		cts0 <= 1'b1;
		lfc[0] <= 8'h60;
		repeat (8) @(posedge clk);
		k = 0;
		for (int i = 0; i < 2; i++)
		begin
			push(0, 8'h11, 40);
			k += ok;
		end
		chk("holding register", 12'(k), 12'h001);
		cts0 <= 1'b0;
		wait_got(34);
		chk("held byte", 12'(u_asp_remote.got), 12'h011);
		// Output buffer and one-deep FIFO hold three; the fourth overruns.
		for (int i = 1; i < 5; i++)
		begin
			u_asp_remote.send(8'(8'ha0 + i), 1'b1);
		end
		for (int i = 1; i < 4; i++)
		begin
			pop(0, 12'(8'ha0 + i));
		end
		u_asp_remote.send(8'ha5, 1'b1);
		pop(0, 12'h8a5);
		$display("Test holding done");
		results();
	end
endmodule
`default_nettype wire

// file: verilog/asp_pkg.sv
// Shared constants and types for the asynchronous serial port core.
// Assumes one clock that also serves as the serial reference clock.
`default_nettype none
package asp_pkg;
	// ---------------------------------------------------------------
	// Structure
	// ---------------------------------------------------------------
	localparam int ASP_INSTANCES = 2;
	localparam int ASP_TX_W = 8;
	localparam int ASP_RX_W = 12;
	localparam int ASP_PTR_W = 5;
	localparam int ASP_CNT_W = 6;
	localparam logic [5:0] ASP_DEPTH = 6'h20;
	localparam logic [5:0] ASP_ONE_DEEP = 6'h01;
	localparam logic [5:0] ASP_TX_LEVEL = 6'h10;
	localparam logic [5:0] ASP_RTS_LEVEL = 6'h1c;
	localparam logic [9:0] ASP_TIMEOUT_TICKS = 10'h1ff;
	// ---------------------------------------------------------------
	// Oversampling
	// ---------------------------------------------------------------
	localparam logic [3:0] ASP_OVS_LAST = 4'hf;
	localparam logic [3:0] ASP_START_MID = 4'h7;
	localparam logic [2:0] ASP_WLEN_BASE = 3'h4;
	localparam logic [1:0] ASP_WLEN_MAX = 2'h3;
	// ---------------------------------------------------------------
	// Line format control fields
	// ---------------------------------------------------------------
	localparam int LFC_BREAK = 0;
	localparam int LFC_PAR_EN = 1;
	localparam int LFC_PAR_EVEN = 2;
	localparam int LFC_TWO_STOP = 3;
	localparam int LFC_FIFO_EN = 4;
	localparam int LFC_WLEN_LO = 5;
	localparam int LFC_WLEN_HI = 6;
	localparam int LFC_STICK = 7;
	// ---------------------------------------------------------------
	// Receive word flags and interrupt positions
	// ---------------------------------------------------------------
	localparam int RXW_FRAME = 8;
	localparam int RXW_PARITY = 9;
	localparam int RXW_BREAK = 10;
	localparam int RXW_OVERRUN = 11;
	localparam int INT_RX = 0;
	localparam int INT_RXTO = 1;
	localparam int INT_TX = 2;
	localparam int INT_MODEM = 3;
	localparam int INT_ERR = 4;
	localparam int INT_W = 5;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} asp_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} asp_rx_state_t;
	// Capacity of a FIFO: full depth, or one holding register.
	function automatic logic [5:0] asp_limit(input logic fifo_en);
		asp_limit = fifo_en ? ASP_DEPTH : ASP_ONE_DEEP;
	endfunction
endpackage
`default_nettype wire

// file: verilog/asp_top.sv
// Asynchronous serial port: two independent transceivers, their FIFOs and
// bit-rate generators. Assumes clk is the serial reference clock and the
// user logic driving the stream and control ports runs on the same clock.
`timescale 1ns/1ps
`default_nettype none

module asp_fifo
	import asp_pkg::*;
#(
	parameter int W = ASP_TX_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Fill and drain
	input wire logic push,
	input wire logic [W-1:0] wdata,
	input wire logic pop,
	input wire logic fifo_en,
	output logic [W-1:0] rdata,
	output logic [ASP_CNT_W-1:0] count,
	output logic full,
	output logic empty
);
	logic [W-1:0] mem_reg [0:31];
	logic [ASP_PTR_W-1:0] wr_reg;
	logic [ASP_PTR_W-1:0] rd_reg;
	logic [ASP_CNT_W-1:0] cnt_reg;

	assign count = cnt_reg;
	assign empty = (cnt_reg == 6'h00);
	// With the FIFO disabled the limit drops to one entry.
	assign full = (cnt_reg >= asp_limit(fifo_en));
	assign rdata = mem_reg[rd_reg];

	always_ff @(posedge clk)
	begin
		if (push && !full)
		begin
			mem_reg[wr_reg] <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push && !full)
			begin
				wr_reg <= wr_reg + 5'h01;
			end
			if (pop && !empty)
			begin
				rd_reg <= rd_reg + 5'h01;
			end
			cnt_reg <= cnt_reg + {5'h00, push && !full} - {5'h00, pop && !empty};
		end
	end
endmodule

module asp_core
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Configuration
	input wire logic [7:0] line_format_control,
	input wire logic [15:0] divisor_integer_part,
	input wire logic [5:0] divisor_fraction_part,
	input wire logic port_enable,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic cts_flow_en,
	input wire logic rts_flow_en,
	input wire logic [INT_W-1:0] int_mask,
	input wire logic [INT_W-1:0] int_clear,
	// Serial pins
	input wire logic serial_in,
	input wire logic clear_to_send_n,
	output logic serial_out,
	output logic request_to_send_n,
	// Transmit stream
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Receive stream
	output logic [11:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// Status
	output logic busy,
	output logic [INT_W-1:0] int_raw,
	output logic interrupt_out,
	output logic tx_dma_req,
	output logic rx_dma_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// ---------------------------------------------------------------
	// Bit-rate generator
	// ---------------------------------------------------------------
	logic [15:0] bd_cnt_reg;
	logic [5:0] bd_acc_reg;
	logic oversample_tick;
	logic [6:0] bd_sum;
	assign bd_sum = {1'b0, bd_acc_reg} + {1'b0, divisor_fraction_part};

	// The fraction carry stretches one period by a cycle.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			bd_cnt_reg <= '0;
			bd_acc_reg <= '0;
			oversample_tick <= 1'b0;
		end
		else
		begin
			oversample_tick <= 1'b0;
			if (divisor_integer_part == 16'h0000)
			begin
				bd_cnt_reg <= '0;
			end
			else if (bd_cnt_reg == 16'h0000)
			begin
				oversample_tick <= 1'b1;
				bd_acc_reg <= bd_sum[5:0];
				bd_cnt_reg <= divisor_integer_part - 16'h0001 + {15'h0000, bd_sum[6]};
			end
			else
			begin
				bd_cnt_reg <= bd_cnt_reg - 16'h0001;
			end
		end
	end
	a_tick_one_wide: assert property (oversample_tick && divisor_integer_part > 16'h0001 |=> !oversample_tick) else $error("tick longer than one cycle");
	a_tick_top_rate: assert property (oversample_tick && divisor_integer_part == 16'h0001 && divisor_fraction_part == 6'h00 |=> oversample_tick) else $error("divisor one does not tick every cycle");

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] s1_reg;
	logic [1:0] s2_reg;
	logic [1:0] s3_reg;
	logic [1:0] pin_reg;
	logic rx_line;
	logic cts_line;
	logic rx_line_q;
	logic cts_line_q;
	assign rx_line = pin_reg[0];
	assign cts_line = pin_reg[1];

	// Only one clock exists, so the pins are the sole crossings.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s1_reg <= 2'h3;
			s2_reg <= 2'h3;
			s3_reg <= 2'h3;
			pin_reg <= 2'h3;
			rx_line_q <= 1'b1;
			cts_line_q <= 1'b1;
		end
		else
		begin
			s1_reg <= {clear_to_send_n, serial_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < 2; i++)
			begin
				if (s2_reg[i] == s3_reg[i])
				begin
					pin_reg[i] <= s3_reg[i];
				end
			end
			rx_line_q <= rx_line;
			cts_line_q <= cts_line;
		end
	end

	// ---------------------------------------------------------------
	// Transmit path
	// ---------------------------------------------------------------
	logic fifo_en;
	logic [2:0] last_bit;
	logic tx_push;
	logic tx_take;
	logic [7:0] tx_head;
	logic [5:0] tx_count;
	logic tx_full;
	logic tx_empty;
	logic [5:0] tx_cnt_nx;
	asp_tx_state_t tx_st;
	logic [7:0] tx_sh_reg;
	logic [2:0] tx_bit_reg;
	logic [3:0] tx_tcnt_reg;
	logic tx_par_reg;
	logic tx_stop2_reg;
	logic tx_line;
	logic par_bit;

	assign fifo_en = line_format_control[LFC_FIFO_EN];
	assign last_bit = ASP_WLEN_BASE + {1'b0, line_format_control[LFC_WLEN_HI:LFC_WLEN_LO]};
	assign tx_push = tx_valid && tx_ready;
	// Flow control holds back only the next character, never one in flight.
	assign tx_take = (tx_st == TX_IDLE) && port_enable && tx_enable && !tx_empty
		&& (!cts_flow_en || !cts_line);
	assign tx_cnt_nx = tx_count + {5'h00, tx_push} - {5'h00, tx_take};
	assign par_bit = line_format_control[LFC_STICK] ? !line_format_control[LFC_PAR_EVEN]
		: (tx_par_reg ^ !line_format_control[LFC_PAR_EVEN]);

	asp_fifo #(.W(ASP_TX_W)) u_tx_fifo (
		.clk(clk),
		.resetn(resetn),
		.push(tx_push),
		.wdata(tx_data),
		.pop(tx_take),
		.fifo_en(fifo_en),
		.rdata(tx_head),
		.count(tx_count),
		.full(tx_full),
		.empty(tx_empty)
	);

	always_comb
	begin
		case (tx_st)
			TX_START: tx_line = 1'b0;
			TX_DATA: tx_line = tx_sh_reg[0];
			TX_PARITY: tx_line = par_bit;
			default: tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			tx_st <= TX_IDLE;
			tx_sh_reg <= '0;
			tx_bit_reg <= '0;
			tx_tcnt_reg <= '0;
			tx_par_reg <= 1'b0;
			tx_stop2_reg <= 1'b0;
		end
		else if (tx_take)
		begin
			tx_st <= TX_START;
			tx_sh_reg <= tx_head;
			tx_tcnt_reg <= '0;
			tx_par_reg <= 1'b0;
			tx_stop2_reg <= 1'b0;
		end
		else if (oversample_tick && tx_st != TX_IDLE)
		begin
			tx_tcnt_reg <= tx_tcnt_reg + 4'h1;
			if (tx_tcnt_reg == ASP_OVS_LAST)
			begin
				case (tx_st)
					TX_START:
					begin
						tx_st <= TX_DATA;
						tx_bit_reg <= '0;
					end
					TX_DATA:
					begin
						tx_sh_reg <= tx_sh_reg >> 1;
						tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == last_bit)
						begin
							tx_st <= line_format_control[LFC_PAR_EN] ? TX_PARITY : TX_STOP;
						end
					end
					TX_PARITY: tx_st <= TX_STOP;
					TX_STOP:
					begin
						if (line_format_control[LFC_TWO_STOP] && !tx_stop2_reg)
						begin
							tx_stop2_reg <= 1'b1;
						end
						else
						begin
							tx_st <= TX_IDLE;
						end
					end
					default: tx_st <= TX_IDLE;
				endcase
			end
		end
	end
	sequence s_tx_launch;
		tx_st == TX_IDLE ##1 tx_st == TX_START;
	endsequence
	a_tx_start_low: assert property (s_tx_launch |=> !serial_out) else $error("start bit not low");
	a_tx_cts_hold: assert property (cts_flow_en && cts_line && tx_st == TX_IDLE |=> tx_st == TX_IDLE) else $error("sent while clear-to-send off");
	a_fifo_one_deep: assert property (!fifo_en && tx_count <= 6'h01 |=> tx_count <= 6'h01) else $error("disabled FIFO holds more than one");

	// ---------------------------------------------------------------
	// Receive path
	// ---------------------------------------------------------------
	asp_rx_state_t rx_st;
	logic [7:0] rx_sh_reg;
	logic [2:0] rx_bit_reg;
	logic [3:0] rx_tcnt_reg;
	logic rx_par_reg;
	logic rx_perr_reg;
	logic rx_zero_reg;
	logic overrun_reg;
	logic rx_done;
	logic rx_push;
	logic rx_pop;
	logic [11:0] rx_wdata;
	logic [11:0] rx_head;
	logic [5:0] rx_count;
	logic rx_full;
	logic rx_empty;
	logic [1:0] rx_shift;

	assign rx_done = (rx_st == RX_STOP) && oversample_tick && (rx_tcnt_reg == ASP_OVS_LAST);
	assign rx_push = rx_done && !rx_full;
	assign rx_shift = ASP_WLEN_MAX - line_format_control[LFC_WLEN_HI:LFC_WLEN_LO];
	assign rx_wdata = {overrun_reg, rx_zero_reg && !rx_line, rx_perr_reg, !rx_line,
		rx_sh_reg >> rx_shift};

	asp_fifo #(.W(ASP_RX_W)) u_rx_fifo (
		.clk(clk),
		.resetn(resetn),
		.push(rx_push),
		.wdata(rx_wdata),
		.pop(rx_pop),
		.fifo_en(fifo_en),
		.rdata(rx_head),
		.count(rx_count),
		.full(rx_full),
		.empty(rx_empty)
	);

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rx_st <= RX_IDLE;
			rx_sh_reg <= '0;
			rx_bit_reg <= '0;
			rx_tcnt_reg <= '0;
			rx_par_reg <= 1'b0;
			rx_perr_reg <= 1'b0;
			rx_zero_reg <= 1'b1;
		end
		else if (rx_st == RX_IDLE)
		begin
			if (port_enable && rx_enable && rx_line_q && !rx_line)
			begin
				rx_st <= RX_START;
				rx_tcnt_reg <= '0;
				rx_par_reg <= 1'b0;
				rx_perr_reg <= 1'b0;
				rx_zero_reg <= 1'b1;
			end
		end
		else if (oversample_tick)
		begin
			rx_tcnt_reg <= rx_tcnt_reg + 4'h1;
			if (rx_st == RX_START && rx_tcnt_reg == ASP_START_MID)
			begin
				rx_tcnt_reg <= '0;
				rx_bit_reg <= '0;
				rx_st <= rx_line ? RX_IDLE : RX_DATA;
			end
			else if (rx_tcnt_reg == ASP_OVS_LAST)
			begin
				rx_zero_reg <= rx_zero_reg && !rx_line;
				case (rx_st)
					RX_DATA:
					begin
						rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
						rx_par_reg <= rx_par_reg ^ rx_line;
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == last_bit)
						begin
							rx_st <= line_format_control[LFC_PAR_EN] ? RX_PARITY : RX_STOP;
						end
					end
					RX_PARITY:
					begin
						rx_perr_reg <= line_format_control[LFC_STICK]
							? (rx_line ^ !line_format_control[LFC_PAR_EVEN])
							: (rx_par_reg ^ rx_line ^ !line_format_control[LFC_PAR_EVEN]);
						rx_st <= RX_STOP;
					end
					default: rx_st <= RX_IDLE;
				endcase
			end
		end
	end

	// A character lost to a full FIFO raises the flag at once; the flag
	// rides along with the next stored character and is then cleared.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			overrun_reg <= 1'b0;
		end
		else if (rx_done && rx_full)
		begin
			overrun_reg <= 1'b1;
		end
		else if (rx_push)
		begin
			overrun_reg <= 1'b0;
		end
	end
	a_start_false: assert property (rx_st == RX_START && oversample_tick && rx_tcnt_reg == ASP_START_MID && rx_line |=> rx_st == RX_IDLE) else $error("false start not rejected");
	a_overrun_keep: assert property (rx_done && rx_full |-> !rx_push ##1 overrun_reg) else $error("overrun wrote FIFO or left flag clear");
	a_frame_flag: assert property (rx_push |-> rx_wdata[RXW_FRAME] == !rx_line && rx_wdata[RXW_OVERRUN] == overrun_reg) else $error("stored flags wrong");

	// ---------------------------------------------------------------
	// Two-entry output buffer
	// ---------------------------------------------------------------
	logic [11:0] slot1_reg;
	logic slot1_valid_reg;
	logic rx_out_fire;
	assign rx_pop = !rx_empty && !slot1_valid_reg;
	assign rx_out_fire = rx_valid && rx_ready;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rx_data <= '0;
			rx_valid <= 1'b0;
			slot1_reg <= '0;
			slot1_valid_reg <= 1'b0;
		end
		else if (rx_out_fire || !rx_valid)
		begin
			rx_valid <= slot1_valid_reg || rx_pop;
			rx_data <= slot1_valid_reg ? slot1_reg : rx_head;
			slot1_valid_reg <= 1'b0;
		end
		else if (rx_pop)
		begin
			slot1_reg <= rx_head;
			slot1_valid_reg <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Interrupts, flow control, DMA and status
	// ---------------------------------------------------------------
	logic [9:0] to_cnt_reg;
	logic to_flag_reg;
	logic modem_flag_reg;
	logic err_flag_reg;
	logic rx_held;
	logic [INT_W-1:0] raw_next;
	assign rx_held = !rx_empty || rx_valid;

	// Flags set by hardware win over a clear in the same cycle.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			to_cnt_reg <= '0;
			to_flag_reg <= 1'b0;
			modem_flag_reg <= 1'b0;
			err_flag_reg <= 1'b0;
		end
		else
		begin
			if (!rx_held || rx_out_fire || rx_push || rx_st != RX_IDLE)
			begin
				to_cnt_reg <= '0;
			end
			else if (oversample_tick && to_cnt_reg != ASP_TIMEOUT_TICKS)
			begin
				to_cnt_reg <= to_cnt_reg + 10'h001;
			end
			to_flag_reg <= (oversample_tick && to_cnt_reg == ASP_TIMEOUT_TICKS - 10'h001)
				|| (to_flag_reg && !int_clear[INT_RXTO] && !rx_out_fire);
			modem_flag_reg <= (cts_line != cts_line_q)
				|| (modem_flag_reg && !int_clear[INT_MODEM]);
			err_flag_reg <= (rx_done && (rx_full || rx_wdata[RXW_FRAME] || rx_wdata[RXW_PARITY]
				|| rx_wdata[RXW_BREAK])) || (err_flag_reg && !int_clear[INT_ERR]);
		end
	end

	always_comb
	begin
		raw_next = '0;
		raw_next[INT_RX] = rx_held;
		raw_next[INT_RXTO] = to_flag_reg;
		raw_next[INT_TX] = tx_count <= (fifo_en ? ASP_TX_LEVEL : 6'h00);
		raw_next[INT_MODEM] = modem_flag_reg;
		raw_next[INT_ERR] = err_flag_reg;
	end

	// Modem-control and infrared modes are absent: request-to-send only
	// follows receive space, and the line is always plain NRZ.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			serial_out <= 1'b1;
			request_to_send_n <= 1'b1;
			tx_ready <= 1'b0;
			busy <= 1'b0;
			int_raw <= '0;
			interrupt_out <= 1'b0;
			tx_dma_req <= 1'b0;
			rx_dma_req <= 1'b0;
		end
		else
		begin
			serial_out <= line_format_control[LFC_BREAK] ? 1'b0 : tx_line;
			request_to_send_n <= rts_flow_en && (rx_count >= ASP_RTS_LEVEL);
			tx_ready <= tx_cnt_nx < asp_limit(fifo_en);
			busy <= !tx_empty || tx_st != TX_IDLE;
			int_raw <= raw_next;
			interrupt_out <= |(raw_next & int_mask);
			tx_dma_req <= tx_cnt_nx < asp_limit(fifo_en);
			rx_dma_req <= !rx_empty;
		end
	end
	a_irq_combined: assert property (interrupt_out == |(int_raw & $past(int_mask))) else $error("combined interrupt mismatch");
	a_break_drive: assert property (line_format_control[LFC_BREAK] |=> !serial_out) else $error("break not driven");
endmodule

module asp_top
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Configuration, one entry per instance
	input wire logic [1:0][7:0] line_format_control,
	input wire logic [1:0][15:0] divisor_integer_part,
	input wire logic [1:0][5:0] divisor_fraction_part,
	input wire logic [1:0] port_enable,
	input wire logic [1:0] tx_enable,
	input wire logic [1:0] rx_enable,
	input wire logic [1:0] cts_flow_en,
	input wire logic [1:0] rts_flow_en,
	input wire logic [1:0][INT_W-1:0] int_mask,
	input wire logic [1:0][INT_W-1:0] int_clear,
	// Serial pins
	input wire logic [1:0] serial_in,
	input wire logic [1:0] clear_to_send_n,
	output logic [1:0] serial_out,
	output logic [1:0] request_to_send_n,
	// Transmit streams
	input wire logic [1:0][7:0] tx_data,
	input wire logic [1:0] tx_valid,
	output logic [1:0] tx_ready,
	// Receive streams
	output logic [1:0][11:0] rx_data,
	output logic [1:0] rx_valid,
	input wire logic [1:0] rx_ready,
	// Status
	output logic [1:0] busy,
	output logic [1:0][INT_W-1:0] int_raw,
	output logic [1:0] interrupt_out,
	output logic [1:0] tx_dma_req,
	output logic [1:0] rx_dma_req
);
	for (genvar g = 0; g < ASP_INSTANCES; g++)
	begin : g_port
		asp_core u_core (
			.clk(clk),
			.resetn(resetn),
			.line_format_control(line_format_control[g]),
			.divisor_integer_part(divisor_integer_part[g]),
			.divisor_fraction_part(divisor_fraction_part[g]),
			.port_enable(port_enable[g]),
			.tx_enable(tx_enable[g]),
			.rx_enable(rx_enable[g]),
			.cts_flow_en(cts_flow_en[g]),
			.rts_flow_en(rts_flow_en[g]),
			.int_mask(int_mask[g]),
			.int_clear(int_clear[g]),
			.serial_in(serial_in[g]),
			.clear_to_send_n(clear_to_send_n[g]),
			.serial_out(serial_out[g]),
			.request_to_send_n(request_to_send_n[g]),
			.tx_data(tx_data[g]),
			.tx_valid(tx_valid[g]),
			.tx_ready(tx_ready[g]),
			.rx_data(rx_data[g]),
			.rx_valid(rx_valid[g]),
			.rx_ready(rx_ready[g]),
			.busy(busy[g]),
			.int_raw(int_raw[g]),
			.interrupt_out(interrupt_out[g]),
			.tx_dma_req(tx_dma_req[g]),
			.rx_dma_req(rx_dma_req[g])
		);
	end
endmodule
`default_nettype wire
